/* File: pkg/sfr_pkg.sv */
package sfr_pkg;

  // ----------------------------------------------------------------
  // Register offsets (index; byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PORT_ZERO_PINS = 8'h80;
  localparam logic [7:0] OFS_STACK_TOP_POINTER = 8'h81;
  localparam logic [7:0] OFS_DATA_POINTER0_LOW = 8'h82;
  localparam logic [7:0] OFS_DATA_POINTER0_HIGH = 8'h83;
  localparam logic [7:0] OFS_DATA_POINTER1_LOW = 8'h84;
  localparam logic [7:0] OFS_DATA_POINTER1_HIGH = 8'h85;
  localparam logic [7:0] OFS_DATA_POINTER_SELECT = 8'h86;
  localparam logic [7:0] OFS_POWER_CONTROL = 8'h87;
  localparam logic [7:0] OFS_TIMER_RUN_CONTROL = 8'h88;
  localparam logic [7:0] OFS_TIMER_MODE_SELECT = 8'h89;
  localparam logic [7:0] OFS_TIMER0_LOW_BYTE = 8'h8a;
  localparam logic [7:0] OFS_TIMER1_LOW_BYTE = 8'h8b;
  localparam logic [7:0] OFS_TIMER0_HIGH_BYTE = 8'h8c;
  localparam logic [7:0] OFS_TIMER1_HIGH_BYTE = 8'h8d;
  localparam logic [7:0] OFS_CLOCK_RATE_CONTROL = 8'h8e;
  localparam logic [7:0] OFS_SPECIAL_FUNCTION_RESERVED = 8'h8f;
  localparam logic [7:0] OFS_PORT_ONE_PINS = 8'h90;
  localparam logic [7:0] OFS_EXTERNAL_IRQ_FLAGS = 8'h91;
  localparam logic [7:0] OFS_PORT_ZERO_ALTFUNC = 8'h95;
  localparam logic [7:0] OFS_PORT_ONE_DIRECTION = 8'h96;
  localparam logic [7:0] OFS_PORT_ONE_ALTFUNC = 8'h97;
  localparam logic [7:0] OFS_SERIAL_PORT_CONTROL = 8'h98;
  localparam logic [7:0] OFS_SERIAL_PORT_BUFFER = 8'h99;
  localparam logic [7:0] OFS_RADIO_PORT_PINS = 8'ha0;
  localparam logic [7:0] OFS_INTERRUPT_ENABLE = 8'ha8;
  localparam logic [7:0] OFS_PULSE_WIDTH_CONTROL = 8'ha9;
  localparam logic [7:0] OFS_PULSE_WIDTH_DUTY = 8'haa;
  localparam logic [7:0] OFS_WDOG_RTC_HIGH_BYTE = 8'hab;
  localparam logic [7:0] OFS_WDOG_RTC_LOW_BYTE = 8'hac;
  localparam logic [7:0] OFS_WDOG_RTC_ACCESS_CTRL = 8'had;
  localparam logic [7:0] OFS_RESET_CAUSE = 8'hb1;
  localparam logic [7:0] OFS_SERIAL_PERIPH_DATA = 8'hb2;
  localparam logic [7:0] OFS_SERIAL_PERIPH_ROUTE = 8'hb3;
  localparam logic [7:0] OFS_SERIAL_PERIPH_DIVIDER = 8'hb4;
  localparam logic [7:0] OFS_TICK_DIVIDER = 8'hb5;
  localparam logic [7:0] OFS_CORE_CLOCK_CONTROL = 8'hb6;
  localparam logic [7:0] OFS_LOW_FREQ_CLOCK_CONFIG = 8'hbf;
  localparam logic [7:0] OFS_TIMER2_CONTROL = 8'hc8;
  localparam logic [7:0] OFS_TIMER2_RELOAD_LOW = 8'hca;
  localparam logic [7:0] OFS_TIMER2_RELOAD_HIGH = 8'hcb;
  localparam logic [7:0] OFS_TIMER2_LOW_BYTE = 8'hcc;
  localparam logic [7:0] OFS_TIMER2_HIGH_BYTE = 8'hcd;
  localparam logic [7:0] OFS_PROGRAM_STATUS_WORD = 8'hd0;
  localparam logic [7:0] OFS_EXTENDED_IRQ_CONTROL = 8'hd8;
  localparam logic [7:0] OFS_MAIN_ARITH_OPERAND = 8'he0;
  localparam logic [7:0] OFS_EXTENDED_IRQ_ENABLE = 8'he8;
  localparam logic [7:0] OFS_MULTIPLY_AUX_OPERAND = 8'hf0;
  localparam logic [7:0] OFS_SILICON_STEPPING = 8'hfe;

  // ----------------------------------------------------------------
  // Reset values that are not zero, and RST_ZERO for all the rest
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_PORT_PINS = 8'hff;
  localparam logic [7:0] RST_STACK_TOP_POINTER = 8'h07;
  localparam logic [7:0] RST_POWER_CONTROL = 8'h30;
  localparam logic [7:0] RST_CLOCK_RATE_CONTROL = 8'h01;
  localparam logic [7:0] RST_EXTERNAL_IRQ_FLAGS = 8'h08;
  localparam logic [7:0] RST_PORT_ONE_DIRECTION = 8'hf4;
  localparam logic [7:0] RST_RADIO_PORT_PINS = 8'h08;
  localparam logic [7:0] RST_RESET_CAUSE = 8'h02;
  localparam logic [7:0] RST_TICK_DIVIDER = 8'h1d;
  localparam logic [7:0] RST_LOW_FREQ_CLOCK_CONFIG = 8'h27;
  localparam logic [7:0] RST_EXTENDED_IRQ_CONTROL = 8'h40;
  localparam logic [7:0] RST_EXTENDED_IRQ_ENABLE = 8'he0;

  // ----------------------------------------------------------------
  // Status word fields and bus layout
  // ----------------------------------------------------------------
  localparam int POS_ARITH_CARRY_FLAG = 7;
  localparam int POS_NIBBLE_CARRY_FLAG = 6;
  localparam int POS_USER_FLAG_ZERO = 5;
  localparam int POS_BANK_SELECT_HIGH = 4;
  localparam int POS_BANK_SELECT_LOW = 3;
  localparam int POS_ARITH_EXCEPTION_FLAG = 2;
  localparam int POS_USER_FLAG_ONE = 1;
  localparam int POS_PARITY_FLAG = 0;
  localparam int WB_ADR_W = 12;
  localparam int WB_BIT_WINDOW = 10;

  // Requests from the core's instruction logic
  typedef struct packed {
    logic acc_we;
    logic [7:0] acc_d;
    logic arith_we;
    logic carry;
    logic nibble_carry;
    logic exception;
    logic bit_we;
    logic [7:0] bit_adr;
    logic bit_val;
  } sfr_core_req_t;

endpackage

/* File: rtl/sfr_regbank.sv */
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps

// Operation
// - Carry flag tracks carry or borrow of arithmetic
// - Nibble carry tracks carry/borrow at nibble boundary
// - Exception flag tracks carry, borrow or overflow
// - Parity flag equals XOR of accumulator bits
// - Bank select bits pick an eight-byte bank
// - User flags change only by software writes
// - Reset loads every register's listed value
// - Status word at 0xD0, bit addressable
module sfr_regbank #(
  parameter logic [7:0] SILICON_STEPPING_VAL = 8'h5a // Arbitrary value
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [sfr_pkg::WB_ADR_W-1:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Core side
  input wire sfr_pkg::sfr_core_req_t i_core,
  output logic [7:0] o_program_status_word,
  output logic [7:0] o_main_arith_operand,
  output logic [7:0] o_stack_top_pointer,
  output logic [7:0] o_bank_base
);
  import sfr_pkg::*;

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------
  function automatic logic is_mapped(logic [7:0] idx);
    case (idx)
      OFS_PORT_ZERO_PINS, OFS_STACK_TOP_POINTER,
      OFS_DATA_POINTER0_LOW, OFS_DATA_POINTER0_HIGH,
      OFS_DATA_POINTER1_LOW, OFS_DATA_POINTER1_HIGH,
      OFS_DATA_POINTER_SELECT, OFS_POWER_CONTROL,
      OFS_TIMER_RUN_CONTROL, OFS_TIMER_MODE_SELECT,
      OFS_TIMER0_LOW_BYTE, OFS_TIMER1_LOW_BYTE,
      OFS_TIMER0_HIGH_BYTE, OFS_TIMER1_HIGH_BYTE,
      OFS_CLOCK_RATE_CONTROL, OFS_SPECIAL_FUNCTION_RESERVED,
      OFS_PORT_ONE_PINS, OFS_EXTERNAL_IRQ_FLAGS,
      OFS_PORT_ZERO_ALTFUNC, OFS_PORT_ONE_DIRECTION,
      OFS_PORT_ONE_ALTFUNC, OFS_SERIAL_PORT_CONTROL,
      OFS_SERIAL_PORT_BUFFER, OFS_RADIO_PORT_PINS,
      OFS_INTERRUPT_ENABLE, OFS_PULSE_WIDTH_CONTROL,
      OFS_PULSE_WIDTH_DUTY, OFS_WDOG_RTC_HIGH_BYTE,
      OFS_WDOG_RTC_LOW_BYTE, OFS_WDOG_RTC_ACCESS_CTRL,
      OFS_RESET_CAUSE, OFS_SERIAL_PERIPH_DATA,
      OFS_SERIAL_PERIPH_ROUTE, OFS_SERIAL_PERIPH_DIVIDER,
      OFS_TICK_DIVIDER, OFS_CORE_CLOCK_CONTROL,
      OFS_LOW_FREQ_CLOCK_CONFIG, OFS_TIMER2_CONTROL,
      OFS_TIMER2_RELOAD_LOW, OFS_TIMER2_RELOAD_HIGH,
      OFS_TIMER2_LOW_BYTE, OFS_TIMER2_HIGH_BYTE,
      OFS_PROGRAM_STATUS_WORD, OFS_EXTENDED_IRQ_CONTROL,
      OFS_MAIN_ARITH_OPERAND, OFS_EXTENDED_IRQ_ENABLE,
      OFS_MULTIPLY_AUX_OPERAND, OFS_SILICON_STEPPING:
        is_mapped = 1'b1;
      default:
        is_mapped = 1'b0;
    endcase
  endfunction

  // Reserved and read-only locations never take a write
  function automatic logic is_writable(logic [7:0] idx);
    is_writable = is_mapped(idx) && (idx != OFS_SPECIAL_FUNCTION_RESERVED)
      && (idx != OFS_SILICON_STEPPING);
  endfunction

  // Only mapped registers at multiples of eight carry single bits
  function automatic logic is_bit_reg(logic [7:0] idx);
    is_bit_reg = is_writable(idx) && (idx[2:0] == 3'b000);
  endfunction

  function automatic logic [7:0] bit_reg(logic [7:0] badr);
    bit_reg = {badr[7:3], 3'b000};
  endfunction

  function automatic logic [7:0] reset_val(logic [7:0] idx);
    case (idx)
      OFS_PORT_ZERO_PINS: reset_val = RST_PORT_PINS;
      OFS_PORT_ONE_PINS: reset_val = RST_PORT_PINS;
      OFS_STACK_TOP_POINTER: reset_val = RST_STACK_TOP_POINTER;
      OFS_POWER_CONTROL: reset_val = RST_POWER_CONTROL;
      OFS_CLOCK_RATE_CONTROL: reset_val = RST_CLOCK_RATE_CONTROL;
      OFS_EXTERNAL_IRQ_FLAGS: reset_val = RST_EXTERNAL_IRQ_FLAGS;
      OFS_PORT_ONE_DIRECTION: reset_val = RST_PORT_ONE_DIRECTION;
      OFS_RADIO_PORT_PINS: reset_val = RST_RADIO_PORT_PINS;
      OFS_RESET_CAUSE: reset_val = RST_RESET_CAUSE;
      OFS_TICK_DIVIDER: reset_val = RST_TICK_DIVIDER;
      OFS_LOW_FREQ_CLOCK_CONFIG: reset_val = RST_LOW_FREQ_CLOCK_CONFIG;
      OFS_EXTENDED_IRQ_CONTROL: reset_val = RST_EXTENDED_IRQ_CONTROL;
      OFS_EXTENDED_IRQ_ENABLE: reset_val = RST_EXTENDED_IRQ_ENABLE;
      default: reset_val = RST_ZERO;
    endcase
  endfunction

  function automatic logic [7:0] put_bit(logic [7:0] v, logic [2:0] p, logic b);
    logic [7:0] r;
    r = v;
    r[p] = b;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Bus request decode
  // ----------------------------------------------------------------
  logic [7:0] mem_q [0:127];
  logic ack_q;
  logic [7:0] rd_q;
  logic req;
  logic bit_win;
  logic [7:0] wb_idx;
  logic [7:0] wb_breg;
  logic [7:0] core_breg;
  logic wb_byte_wr;
  logic wb_bit_wr;
  logic core_bit_wr;
  logic [7:0] acc_d;
  logic [7:0] psw_d;
  logic [7:0] rd_d;

  // A new request is only taken while no answer is standing
  assign req = i_wb_cyc && i_wb_stb && !ack_q;
  assign bit_win = i_wb_adr[WB_BIT_WINDOW];
  assign wb_idx = i_wb_adr[9:2];
  assign wb_breg = bit_reg(wb_idx);
  assign core_breg = bit_reg(i_core.bit_adr);
  assign wb_byte_wr = req && i_wb_we && i_wb_sel[0] && !bit_win
    && is_writable(wb_idx);
  assign wb_bit_wr = req && i_wb_we && i_wb_sel[0] && bit_win
    && is_bit_reg(wb_breg);
  assign core_bit_wr = i_core.bit_we && is_bit_reg(core_breg);

  // ----------------------------------------------------------------
  // Accumulator and status word next values
  // ----------------------------------------------------------------
  always_comb
  begin
    acc_d = mem_q[OFS_MAIN_ARITH_OPERAND[6:0]];
    if (wb_byte_wr && (wb_idx == OFS_MAIN_ARITH_OPERAND))
    begin
      acc_d = i_wb_dat[7:0];
    end
    if (wb_bit_wr && (wb_breg == OFS_MAIN_ARITH_OPERAND))
    begin
      acc_d = put_bit(acc_d, wb_idx[2:0], i_wb_dat[0]);
    end
    if (core_bit_wr && (core_breg == OFS_MAIN_ARITH_OPERAND))
    begin
      acc_d = put_bit(acc_d, i_core.bit_adr[2:0], i_core.bit_val);
    end
    // Instruction results win over a bus write in the same cycle
    if (i_core.acc_we)
    begin
      acc_d = i_core.acc_d;
    end
  end

  always_comb
  begin
    psw_d = mem_q[OFS_PROGRAM_STATUS_WORD[6:0]];
    if (wb_byte_wr && (wb_idx == OFS_PROGRAM_STATUS_WORD))
    begin
      psw_d = i_wb_dat[7:0];
    end
    if (wb_bit_wr && (wb_breg == OFS_PROGRAM_STATUS_WORD))
    begin
      psw_d = put_bit(psw_d, wb_idx[2:0], i_wb_dat[0]);
    end
    if (core_bit_wr && (core_breg == OFS_PROGRAM_STATUS_WORD))
    begin
      psw_d = put_bit(psw_d, i_core.bit_adr[2:0], i_core.bit_val);
    end
    // Arithmetic touches only the three result flags, never the user flags
    if (i_core.arith_we)
    begin
      psw_d[POS_ARITH_CARRY_FLAG] = i_core.carry;
      psw_d[POS_NIBBLE_CARRY_FLAG] = i_core.nibble_carry;
      psw_d[POS_ARITH_EXCEPTION_FLAG] = i_core.exception;
    end
    // Parity follows the next accumulator so it never lags a cycle
    psw_d[POS_PARITY_FLAG] = ^acc_d;
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      for (int i = 0; i < 128; i++)
      begin
        mem_q[i] <= reset_val({1'b1, 7'(i)});
      end
    end
    else
    begin
      if (wb_byte_wr)
      begin
        mem_q[wb_idx[6:0]] <= i_wb_dat[7:0];
      end
      if (wb_bit_wr)
      begin
        mem_q[wb_breg[6:0]][wb_idx[2:0]] <= i_wb_dat[0];
      end
      if (core_bit_wr)
      begin
        mem_q[core_breg[6:0]][i_core.bit_adr[2:0]] <= i_core.bit_val;
      end
      // Last assignments win for the two registers with merged sources
      mem_q[OFS_MAIN_ARITH_OPERAND[6:0]] <= acc_d;
      mem_q[OFS_PROGRAM_STATUS_WORD[6:0]] <= psw_d;
    end
  end

  // ----------------------------------------------------------------
  // Read path and acknowledge
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_d = 8'h00;
    if (bit_win)
    begin
      if (is_bit_reg(wb_breg))
      begin
        rd_d = {7'h00, mem_q[wb_breg[6:0]][wb_idx[2:0]]};
      end
    end
    else if (wb_idx == OFS_SILICON_STEPPING)
    begin
      rd_d = SILICON_STEPPING_VAL;
    end
    else if (is_writable(wb_idx))
    begin
      rd_d = mem_q[wb_idx[6:0]];
    end
  end

  // Unmapped addresses still answer, reading zero, so no master hangs
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= req;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rd_q <= 8'h00;
    end
    else if (req && !i_wb_we)
    begin
      rd_q <= rd_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_wb_ack = ack_q;
  assign o_wb_dat = {24'h00_0000, rd_q};
  assign o_program_status_word = mem_q[OFS_PROGRAM_STATUS_WORD[6:0]];
  assign o_main_arith_operand = mem_q[OFS_MAIN_ARITH_OPERAND[6:0]];
  assign o_stack_top_pointer = mem_q[OFS_STACK_TOP_POINTER[6:0]];
  // Bank base is bank number times eight: 0x00, 0x08, 0x10, 0x18
  assign o_bank_base = {3'b000,
    mem_q[OFS_PROGRAM_STATUS_WORD[6:0]][POS_BANK_SELECT_HIGH],
    mem_q[OFS_PROGRAM_STATUS_WORD[6:0]][POS_BANK_SELECT_LOW], 3'b000};

endmodule // sfr_regbank

/* File: tb/sfr_regbank_properties.sv */
`timescale 1ns/1ps
module sfr_regbank_checker
  import sfr_pkg::*;
#(
  parameter logic [7:0] SILICON_STEPPING_VAL = 8'h5a // Arbitrary value
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [sfr_pkg::WB_ADR_W-1:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire sfr_pkg::sfr_core_req_t i_core,
  input wire logic [7:0] o_program_status_word,
  input wire logic [7:0] o_main_arith_operand,
  input wire logic [7:0] o_stack_top_pointer,
  input wire logic [7:0] o_bank_base
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  logic take;
  logic quiet;
  assign take = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign quiet = !i_core.acc_we && !i_core.arith_we && !i_core.bit_we;
  // Core-side writes are excluded so the bus value alone decides
  sequence s_psw_wr;
    take && i_wb_we && i_wb_sel[0] && i_wb_adr == 12'h340 && quiet;
  endsequence
  sequence s_psw_rd;
    take && !i_wb_we && i_wb_adr == 12'h340 && quiet;
  endsequence
  a_ack_follows: assert property (take |=> o_wb_ack)
    else $error("Bus request not answered in the next cycle");
  a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("Acknowledge longer than one cycle");
  a_ack_caused: assert property (o_wb_ack |-> $past(take))
    else $error("Acknowledge without a request");
  a_carry_flag: assert property (
    i_core.arith_we |=> o_program_status_word[7] == $past(i_core.carry))
    else $error("Carry flag wrong after arithmetic update");
  a_nibble_flag: assert property (
    i_core.arith_we |=> o_program_status_word[6] == $past(i_core.nibble_carry))
    else $error("Nibble carry wrong after arithmetic update");
  a_exception_flag: assert property (
    i_core.arith_we |=> o_program_status_word[2] == $past(i_core.exception))
    else $error("Exception flag wrong after arithmetic update");
  a_parity_acc: assert property (
    o_program_status_word[0] == ^o_main_arith_operand)
    else $error("Parity flag differs from accumulator parity");
  a_bank_base: assert property (
    o_bank_base == {3'b000, o_program_status_word[4:3], 3'b000})
    else $error("Bank base does not follow bank select");
  a_user_flags: assert property (
    !(take && i_wb_we) && !i_core.bit_we
    |=> $stable(o_program_status_word[5]) && $stable(o_program_status_word[1]))
    else $error("User flag changed without a software write");
  a_psw_read: assert property (
    s_psw_rd |=> o_wb_ack && o_wb_dat[7:0] == $past(o_program_status_word))
    else $error("Status word read returns wrong value");
  a_psw_write: assert property (
    s_psw_wr |=> o_program_status_word[7:1] == $past(i_wb_dat[7:1]))
    else $error("Status word write not stored");
endmodule // sfr_regbank_checker

bind sfr_regbank sfr_regbank_checker #(.SILICON_STEPPING_VAL(SILICON_STEPPING_VAL)) chk_u (
  .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat), .i_wb_sel(i_wb_sel),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_core(i_core),
  .o_program_status_word(o_program_status_word), .o_main_arith_operand(o_main_arith_operand),
  .o_stack_top_pointer(o_stack_top_pointer), .o_bank_base(o_bank_base)
);

/* File: tb/sfr_reset_map_and_status_word_tb_top.sv */
`timescale 1ns/1ps
module sfr_reset_map_and_status_word_tb_top;
  import sfr_pkg::*;
  typedef struct {logic [7:0] ofs, rst, wr, rd;} sfr_row_t;
  // Reserved, read-only and unmapped places sit at the end of the table
  sfr_row_t rows[16] = '{'{8'h80, 8'hff, 8'ha5, 8'ha5}, '{8'h81, 8'h07, 8'ha5, 8'ha5},
    '{8'h87, 8'h30, 8'ha5, 8'ha5}, '{8'h8e, 8'h01, 8'ha5, 8'ha5}, '{8'h91, 8'h08, 8'ha5, 8'ha5},
    '{8'h96, 8'hf4, 8'ha5, 8'ha5}, '{8'ha0, 8'h08, 8'ha5, 8'ha5}, '{8'hb1, 8'h02, 8'ha5, 8'ha5},
    '{8'hb5, 8'h1d, 8'ha5, 8'ha5}, '{8'hbf, 8'h27, 8'ha5, 8'ha5}, '{8'hd8, 8'h40, 8'ha5, 8'ha5},
    '{8'he8, 8'he0, 8'ha5, 8'ha5}, '{8'hf0, 8'h00, 8'ha5, 8'ha5}, '{8'h8f, 8'h00, 8'ha5, 8'h00},
    '{8'hfe, 8'h5a, 8'ha5, 8'h5a}, '{8'h92, 8'h00, 8'ha5, 8'h00}};
  logic clk = 1'b0;
  logic nrst, cyc, stb, we;
  logic [11:0] adr;
  logic [31:0] dat, rdat;
  logic [3:0] sel;
  logic ack;
  sfr_core_req_t core, r;
  logic [7:0] program_status_word, acc, sp, bank, q, v;
  int failures = 0;
  int compares = 0;

  sfr_regbank #(.SILICON_STEPPING_VAL(8'h5a)) dut_u (
    .i_clk_sys(clk), .i_nrst(nrst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_dat(dat), .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_core(core), .o_program_status_word(program_status_word), .o_main_arith_operand(acc),
    .o_stack_top_pointer(sp), .o_bank_base(bank)
  );

  always #2.5 clk = ~clk;

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One classic cycle; only the watchdog ends the wait for a dead slave
  task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h00_0000, d};
    sel <= 4'hf;
    do
    begin
      @(posedge clk);
    end
    while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic core_op(input sfr_core_req_t c);
    @(posedge clk);
    core <= c;
    @(posedge clk);
    core <= '0;
    #1;
  endtask

  task automatic summarize;
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0)
    begin
      $display("STATUS OK");
    end
    else
    begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial
  begin
    #50000;
    failures++;
    summarize();
  end

  initial
  begin
    nrst = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = '0;
    dat = '0;
    sel = '0;
    core = '0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    foreach (rows[i])
    begin
      wb(1'b0, {2'b00, rows[i].ofs, 2'b00}, 8'h00);
      chk("reset value", rows[i].rst, q);
      wb(1'b1, {2'b00, rows[i].ofs, 2'b00}, rows[i].wr);
      wb(1'b0, {2'b00, rows[i].ofs, 2'b00}, 8'h00);
      chk("readback", rows[i].rd, q);
    end
    // Accumulator is zero, so a written parity bit must not stick
    wb(1'b1, 12'h340, 8'hff);
    wb(1'b0, 12'h340, 8'h00);
    chk("status write", 8'hfe, q);
    for (int b = 0; b < 4; b++)
    begin
      wb(1'b1, 12'h340, 8'(b << 3));
      chk("bank base", 8'(b << 3), bank);
    end
    wb(1'b1, {2'b01, 8'hd5, 2'b00}, 8'h01);
    wb(1'b1, {2'b01, 8'hd1, 2'b00}, 8'h01);
    wb(1'b0, {2'b01, 8'hd5, 2'b00}, 8'h00);
    chk("bit read", 8'h01, q);
    wb(1'b0, 12'h340, 8'h00);
    chk("status bits", 8'h3a, q);
    for (int k = 0; k < 8; k++)
    begin
      r = '0;
      r.arith_we = 1'b1;
      {r.carry, r.nibble_carry, r.exception} = 3'(k);
      core_op(r);
      v = {r.carry, r.nibble_carry, 3'b111, r.exception, 2'b10};
      chk("arith flags", v, program_status_word);
    end
    for (int k = 0; k < 4; k++)
    begin
      v = 8'h07 << (k * 2);
      v = v ^ 8'(k);
      r = '0;
      r.acc_we = 1'b1;
      r.acc_d = v;
      core_op(r);
      chk("parity", {7'h00, ^v}, {7'h00, program_status_word[0]});
      chk("accumulator", v, acc);
    end
    // Core-side bit write clears user flag zero; accumulator parity stays even
    r = '0;
    r.bit_we = 1'b1;
    r.bit_adr = 8'hd5;
    r.bit_val = 1'b0;
    core_op(r);
    chk("core bit clear", 8'hde, program_status_word);
    @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    #1;
    chk("status after reset", 8'h00, program_status_word);
    chk("stack after reset", 8'h07, sp);
    @(posedge clk);
    nrst <= 1'b1;
    wb(1'b0, {2'b00, 8'h81, 2'b00}, 8'h00);
    chk("stack read after reset", 8'h07, q);
    summarize();
  end
endmodule // sfr_reset_map_and_status_word_tb_top
